// ---- shared/tcs_params.svh ----
// Offsets, field positions and reset values of the timer clock source block
`ifndef TCS_PARAMS_SVH
`define TCS_PARAMS_SVH

// Byte addresses of the register words
`define TCS_OFS_GTC 4'h0
`define TCS_OFS_CSEL 4'h4
`define TCS_OFS_STAT 4'h8

// general_timer_control bit positions
`define TCS_GTC_TSM 7
`define TCS_GTC_ASYNC_PRESCALER_RESET 1
`define TCS_GTC_SHARED_PRESCALER_RESET 0

// Clock select register field positions
`define TCS_CS0_LSB 0
`define TCS_CS1_LSB 4
`define TCS_PRR_BIT 8

// Status register field positions
`define TCS_STAT_PRESC_LSB 0
`define TCS_STAT_PIN0_BIT 16
`define TCS_STAT_PIN1_BIT 17

// Prescaler width, reset values
`define TCS_PRESC_W 10
`define TCS_GTC_RESET 8'h00
`define TCS_PRESC_RESET 10'h000

// Edge-to-tick delay bounds in half cycles (2.5 and 3.5 cycles)
`define TCS_EDGE_DLY_MIN_HALF 5
`define TCS_EDGE_DLY_MAX_HALF 7

`endif

// ---- shared/tcs_pkg.sv ----
// Types shared by the timer clock source modules
package tcs_pkg;

  // Clock select codes of a timer
  typedef enum logic [2:0] {
    TCS_CS_STOP = 3'h0,
    TCS_CS_DIRECT = 3'h1,
    TCS_CS_DIV8 = 3'h2,
    TCS_CS_DIV64 = 3'h3,
    TCS_CS_DIV256 = 3'h4,
    TCS_CS_DIV1024 = 3'h5,
    TCS_CS_EXT_FALL = 3'h6,
    TCS_CS_EXT_RISE = 3'h7
  } tcs_csel_t;

  // Bus slave states, one-hot
  typedef enum logic [1:0] {
    TCS_BUS_IDLE = 2'h1,
    TCS_BUS_ACK = 2'h2
  } tcs_bus_t;

  // Stored bits of general_timer_control
  typedef struct packed {
    logic timerSyncMode;
    logic asyncPrescalerReset;
    logic sharedPrescalerReset;
  } tcs_gtc_t;

  // Edge detector result for one pin
  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } tcs_edge_t;

  // Synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tcs_sync_t;

  // Whole state of the clock source block
  typedef struct packed {
    tcs_bus_t bus;
    tcs_gtc_t gtc;
    tcs_csel_t cs0;
    tcs_csel_t cs1;
    logic powerReduction;
    logic [9:0] presc;
    logic [31:0] rdata;
  } tcs_state_t;

endpackage : tcs_pkg

// ---- hw/tcs_pin_sync.sv ----
// Synchroniser and edge detector for one external timer clock pin
`timescale 1ns/1ns
`default_nettype none

module tcs_pin_sync
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic pinIn,
  output tcs_edge_t edges
);

  logic latchQ;
  tcs_sync_t st_r;
  tcs_sync_t st_nxt;

  // Input latch open in the high clock phase, so the pin is taken at the fall
  always_latch begin
    if (clk && clkEn) begin
      latchQ <= pinIn;
    end
  end

  // Two sync stages, then one history stage for the edge detector
  always_comb begin
    st_nxt = st_r;
    if (clkEn) begin
      st_nxt.s1 = latchQ;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
    end
  end

  // Stages update on the rising edge only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Edge pulses last exactly one cycle since s3 catches up with s2
  assign edges.rise = st_r.s2 & ~st_r.s3;
  assign edges.fall = ~st_r.s2 & st_r.s3;
  assign edges.level = st_r.s2;

  default clocking cbSync @(posedge clk); endclocking
  default disable iff (sys_rst || !clkEn);

  sequence sPinRose;
    !pinIn ##1 pinIn;
  endsequence

  a_edge_one_pulse: assert property (edges.rise |=> !edges.rise)
    else $error("rise pulse longer than one cycle");
  // A change in the low phase waits for the latch to open, hence one more cycle
  a_edge_delay_win: assert property (sPinRose |-> ##[2:3] edges.rise)
    else $error("pin edge not seen within 2.5 to 3.5 cycles");
  a_edge_no_early: assert property (sPinRose |-> !edges.rise ##1 !edges.rise)
    else $error("pin edge reported too early");

endmodule : tcs_pin_sync

`default_nettype wire

// ---- hw/tcs_clock_source.sv ----
// Timer clock source: shared prescaler, pin sync, clock select, control register
// Behaviour
// - Sample each timer pin through a synchroniser.
// - Sync flops on rising edge, latch open high.
// - One tick per rising (7) or falling (6) edge.
// - Pin edge to count takes 2.5 to 3.5 cycles.
// - External clock goes undivided to the counter.
// - Sync mode holds written prescaler reset bits.
// - Clearing sync mode clears both reset bits.
// - Shared prescaler reset self-clears unless sync mode.
// - Clock select zero gives no ticks.
// - Select codes: stop, direct, 8/64/256/1024, edges.
// - Prescaler runs free whatever the select.
`include "tcs_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tcs_clock_source
  import tcs_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic externalTimerClockPin0,
  input wire logic externalTimerClockPin1,
  output logic timerTickClock0,
  output logic timerTickClock1,
  output logic asyncPrescalerReset
);

  localparam tcs_state_t ST_RESET = '{
    bus: TCS_BUS_IDLE,
    gtc: '0,
    cs0: TCS_CS_STOP,
    cs1: TCS_CS_STOP,
    powerReduction: 1'b0,
    presc: `TCS_PRESC_RESET,
    rdata: 32'h0
  };

  tcs_state_t st_r;
  tcs_state_t st_nxt;
  tcs_edge_t pinEdge0;
  tcs_edge_t pinEdge1;
  logic busReq;
  logic busAck;
  logic wrTake;
  logic wrGtc;
  logic wrCsel;
  logic [31:0] readMux;

  // Tick for one timer from its select, the prescaler and its pin edges
  function automatic logic tickFor(input tcs_csel_t sel,
                                   input logic [9:0] cnt,
                                   input tcs_edge_t e);
    case (sel)
      TCS_CS_STOP: tickFor = 1'b0;
      TCS_CS_DIRECT: tickFor = 1'b1;
      TCS_CS_DIV8: tickFor = &cnt[2:0];
      TCS_CS_DIV64: tickFor = &cnt[5:0];
      TCS_CS_DIV256: tickFor = &cnt[7:0];
      TCS_CS_DIV1024: tickFor = &cnt[9:0];
      TCS_CS_EXT_FALL: tickFor = e.fall;
      TCS_CS_EXT_RISE: tickFor = e.rise;
      default: tickFor = 1'b0;
    endcase
  endfunction : tickFor

  // One synchroniser per external pin
  tcs_pin_sync uSync0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinIn(externalTimerClockPin0),
    .edges(pinEdge0)
  );

  tcs_pin_sync uSync1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .pinIn(externalTimerClockPin1),
    .edges(pinEdge1)
  );

  // Bus handshake: one wait cycle, then the access completes
  assign busReq = avs_read | avs_write;
  assign busAck = (st_r.bus == TCS_BUS_ACK);
  assign avs_waitrequest = busReq & ~busAck;
  assign wrTake = avs_write & busAck;
  assign wrGtc = wrTake & (avs_address == `TCS_OFS_GTC) & avs_byteenable[0];
  assign wrCsel = wrTake & (avs_address == `TCS_OFS_CSEL);

  // Read word for the addressed register; unmapped words read zero
  always_comb begin
    readMux = 32'h0;
    case (avs_address)
      `TCS_OFS_GTC: begin
        readMux[`TCS_GTC_TSM] = st_r.gtc.timerSyncMode;
        readMux[`TCS_GTC_ASYNC_PRESCALER_RESET] = st_r.gtc.asyncPrescalerReset;
        readMux[`TCS_GTC_SHARED_PRESCALER_RESET] = st_r.gtc.sharedPrescalerReset;
      end
      `TCS_OFS_CSEL: begin
        readMux[`TCS_CS0_LSB +: 3] = st_r.cs0;
        readMux[`TCS_CS1_LSB +: 3] = st_r.cs1;
        readMux[`TCS_PRR_BIT] = st_r.powerReduction;
      end
      `TCS_OFS_STAT: begin
        readMux[`TCS_STAT_PRESC_LSB +: `TCS_PRESC_W] = st_r.presc;
        readMux[`TCS_STAT_PIN0_BIT] = pinEdge0.level;
        readMux[`TCS_STAT_PIN1_BIT] = pinEdge1.level;
      end
      default: readMux = 32'h0;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    if (clkEn) begin
      // Prescaler counts every cycle, held at zero only by its reset bit
      if (st_r.gtc.sharedPrescalerReset) begin
        st_nxt.presc = `TCS_PRESC_RESET;
      end else begin
        st_nxt.presc = st_r.presc + 10'h001;
      end
      // Reset bits last one cycle unless sync mode keeps them
      if (!st_r.gtc.timerSyncMode) begin
        st_nxt.gtc.sharedPrescalerReset = 1'b0;
        st_nxt.gtc.asyncPrescalerReset = 1'b0;
      end
      // Bus slave sequencing, read word captured one cycle ahead
      case (st_r.bus)
        TCS_BUS_IDLE: begin
          if (busReq) begin
            st_nxt.bus = TCS_BUS_ACK;
            st_nxt.rdata = avs_read ? readMux : st_r.rdata;
          end
        end
        TCS_BUS_ACK: begin
          st_nxt.bus = TCS_BUS_IDLE;
        end
        default: begin
          st_nxt.bus = TCS_BUS_IDLE;
        end
      endcase
      // Control register write; leaving sync mode drops both reset bits
      if (wrGtc) begin
        st_nxt.gtc.timerSyncMode = avs_writedata[`TCS_GTC_TSM];
        if (st_r.gtc.timerSyncMode && !avs_writedata[`TCS_GTC_TSM]) begin
          st_nxt.gtc.sharedPrescalerReset = 1'b0;
          st_nxt.gtc.asyncPrescalerReset = 1'b0;
        end else begin
          st_nxt.gtc.sharedPrescalerReset = avs_writedata[`TCS_GTC_SHARED_PRESCALER_RESET];
          st_nxt.gtc.asyncPrescalerReset = avs_writedata[`TCS_GTC_ASYNC_PRESCALER_RESET];
        end
      end
      // Clock selects and power reduction
      if (wrCsel && avs_byteenable[0]) begin
        st_nxt.cs0 = tcs_csel_t'(avs_writedata[`TCS_CS0_LSB +: 3]);
        st_nxt.cs1 = tcs_csel_t'(avs_writedata[`TCS_CS1_LSB +: 3]);
      end
      if (wrCsel && avs_byteenable[1]) begin
        st_nxt.powerReduction = avs_writedata[`TCS_PRR_BIT];
      end
    end
  end

  // Single state register, synchronous reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata = st_r.rdata;
  assign asyncPrescalerReset = st_r.gtc.asyncPrescalerReset;

  // Ticks are strobes decoded from flops; timer 1 is gated by power reduction
  // so a forgotten power bit shows up as a stopped counter, not a glitch
  assign timerTickClock0 = clkEn & tickFor(st_r.cs0, st_r.presc, pinEdge0);
  assign timerTickClock1 = clkEn & ~st_r.powerReduction
                         & tickFor(st_r.cs1, st_r.presc, pinEdge1);

  default clocking cbMain @(posedge clk); endclocking
  default disable iff (sys_rst || !clkEn);

  sequence sSyncHeld;
    st_r.gtc.timerSyncMode && !wrGtc;
  endsequence

  sequence sFreeRun;
    !st_r.gtc.timerSyncMode && !wrGtc;
  endsequence

  sequence sLeaveSync;
    wrGtc && st_r.gtc.timerSyncMode && !avs_writedata[`TCS_GTC_TSM];
  endsequence

  a_stop_no_tick: assert property (st_r.cs0 == TCS_CS_STOP |-> !timerTickClock0)
    else $error("timer 0 ticked while stopped");
  a_presc_free_run: assert property (
    !st_r.gtc.sharedPrescalerReset |=> st_r.presc == $past(st_r.presc) + 10'h001)
    else $error("prescaler did not advance");
  a_shared_rst_clear: assert property (
    sFreeRun ##0 st_r.gtc.sharedPrescalerReset |=> !st_r.gtc.sharedPrescalerReset)
    else $error("shared prescaler reset not cleared");
  a_async_rst_clear: assert property (
    sFreeRun ##0 st_r.gtc.asyncPrescalerReset |=> !asyncPrescalerReset)
    else $error("async prescaler reset not cleared");
  a_sync_mode_hold: assert property (
    sSyncHeld ##0 st_r.gtc.sharedPrescalerReset |=> st_r.gtc.sharedPrescalerReset
      ##0 st_r.presc == `TCS_PRESC_RESET)
    else $error("sync mode lost the prescaler reset");
  a_sync_release: assert property (
    sLeaveSync ##0 st_r.gtc.sharedPrescalerReset
      |=> !st_r.gtc.sharedPrescalerReset && !asyncPrescalerReset
      ##1 st_r.presc == 10'h001)
    else $error("leaving sync mode did not release prescalers");
  a_ext_fall_pass: assert property (
    st_r.cs1 == TCS_CS_EXT_FALL && !st_r.powerReduction
      |-> timerTickClock1 == pinEdge1.fall)
    else $error("falling edge tick mismatch");
  a_ext_rise_pass: assert property (
    st_r.cs0 == TCS_CS_EXT_RISE |-> timerTickClock0 == pinEdge0.rise)
    else $error("rising edge tick mismatch");
  a_div8_spacing: assert property (
    st_r.cs0 == TCS_CS_DIV8 && timerTickClock0 && !st_r.gtc.sharedPrescalerReset
      ##1 st_r.cs0 == TCS_CS_DIV8 |-> !timerTickClock0 [*7])
    else $error("divide by 8 ticked too soon");
  a_bus_one_wait: assert property (
    busReq && st_r.bus == TCS_BUS_IDLE |=> !avs_waitrequest || !busReq)
    else $error("bus access not answered after one wait cycle");

endmodule : tcs_clock_source

`default_nettype wire

// ---- testbench/tcs_ext_clk_model.sv ----
// External clock source that drives the timer clock pins
`timescale 1ns/1ns
`default_nettype none

module tcs_ext_clk_model #(
  parameter int HALF_LEN = 3
) (
  input wire logic clk,
  input wire logic run,
  output logic pin
);
  int phaseCnt;

  initial begin
    pin = 1'b0;
    phaseCnt = 0;
  end

  // Each phase lasts HALF_LEN cycles, so the rate stays below clk/2.5
  // Between bursts the pin holds its level, so select changes are safe
  always @(posedge clk) begin
    if (run) begin
      if (phaseCnt >= HALF_LEN - 1) begin
        pin <= ~pin;
        phaseCnt <= 0;
      end else begin
        phaseCnt <= phaseCnt + 1;
      end
    end
  end
endmodule : tcs_ext_clk_model

`default_nettype wire

// ---- testbench/tcs_clock_source_tb.sv ----
// Self-checking bench for the timer clock source block
`include "tcs_params.svh"
`timescale 1ns/1ns
`default_nettype none

module tcs_clock_source_tb;
  import tcs_pkg::*;
  logic clk, sys_rst, clkEn, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic pin, tick0, tick1, asyncRst, run, pinPrev;
  int error_cnt, n_tests, tick0Cnt, tick1Cnt, riseCnt, fallCnt, d0, d1, dr, df;

  tcs_clock_source u_tcs_clock_source (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .externalTimerClockPin0(pin), .externalTimerClockPin1(pin),
    .timerTickClock0(tick0), .timerTickClock1(tick1), .asyncPrescalerReset(asyncRst));

  tcs_ext_clk_model #(.HALF_LEN(3)) u_tcs_ext_clk_model (.clk(clk), .run(run), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Count pulses and pin edges mid-cycle, where all values have settled
  always @(negedge clk) begin
    if (tick0 === 1'b1) tick0Cnt++;
    if (tick1 === 1'b1) tick1Cnt++;
    if (pin === 1'b1 && pinPrev === 1'b0) riseCnt++;
    if (pin === 1'b0 && pinPrev === 1'b1) fallCnt++;
    pinPrev = pin;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until a rising edge sees waitrequest low; data taken there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) error_cnt++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rdchk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, q, exp);
  endtask : rdchk

  task automatic win(input int len);
    int a0, a1;
    @(posedge clk);
    a0 = tick0Cnt;
    a1 = tick1Cnt;
    repeat (len) @(posedge clk);
    d0 = tick0Cnt - a0;
    d1 = tick1Cnt - a1;
  endtask : win

  task automatic t_reset;
    rdchk("gtc", `TCS_OFS_GTC, 32'h0);
    rdchk("csel", `TCS_OFS_CSEL, 32'h0);
    bus(1'b1, 4'hc, 32'hff);
    rdchk("unmapped", 4'hc, 32'h0);
    rdchk("gtc after unmapped", `TCS_OFS_GTC, 32'h0);
    win(64);
    check("stopped tick0", d0, 0);
    check("stopped tick1", d1, 0);
    $display("test reset done");
  endtask : t_reset

  // A 2048-cycle window holds exactly 2048/N taps whatever the prescaler phase
  task automatic t_selects;
    int sh[6] = '{0, 0, 3, 6, 8, 10};
    for (int c = 1; c <= 5; c++) begin
      bus(1'b1, `TCS_OFS_CSEL, {24'h0, 1'b0, c[2:0], 1'b0, c[2:0]});
      win(2048);
      check("tick0 rate", d0, 2048 >> sh[c]);
      check("tick1 rate", d1, 2048 >> sh[c]);
    end
    $display("test selects done");
  endtask : t_selects

  task automatic t_sync;
    bus(1'b1, `TCS_OFS_CSEL, 32'h22);
    bus(1'b1, `TCS_OFS_GTC, 32'h83);
    rdchk("gtc held", `TCS_OFS_GTC, 32'h83);
    check("async reset held", asyncRst, 1);
    win(256);
    check("halted tick0", d0, 0);
    check("halted tick1", d1, 0);
    rdchk("stat held", `TCS_OFS_STAT, 32'h0);
    bus(1'b1, `TCS_OFS_GTC, 32'h0);
    rdchk("gtc released", `TCS_OFS_GTC, 32'h0);
    check("async reset released", asyncRst, 0);
    win(256);
    check("resumed tick0", d0, 32);
    check("resumed tick1", d1, 32);
    bus(1'b1, `TCS_OFS_GTC, 32'h1);
    rdchk("shared reset clears", `TCS_OFS_GTC, 32'h0);
    bus(1'b1, `TCS_OFS_GTC, 32'h2);
    rdchk("async reset clears", `TCS_OFS_GTC, 32'h0);
    check("async reset pin", asyncRst, 0);
    $display("test sync done");
  endtask : t_sync

  task automatic ext_run;
    int a0, a1, r, f;
    a0 = tick0Cnt;
    a1 = tick1Cnt;
    r = riseCnt;
    f = fallCnt;
    @(posedge clk);
    run <= 1'b1;
    repeat (60) @(posedge clk);
    run <= 1'b0;
    repeat (8) @(posedge clk);
    d0 = tick0Cnt - a0;
    d1 = tick1Cnt - a1;
    dr = riseCnt - r;
    df = fallCnt - f;
  endtask : ext_run

  // Selects change only while the pin stands still between bursts
  task automatic t_ext;
    bus(1'b1, `TCS_OFS_CSEL, 32'h67);
    ext_run();
    check("rise ticks", d0, dr);
    check("fall ticks", d1, df);
    check("rises seen", dr, 10);
    bus(1'b1, `TCS_OFS_CSEL, 32'h167);
    ext_run();
    check("rise ticks gated run", d0, dr);
    check("gated tick1", d1, 0);
    $display("test external done");
  endtask : t_ext

  task automatic results;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // Hang guard, well beyond the 11k cycles the tests need
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    run = 1'b0;
    pinPrev = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_selects();
    t_sync();
    t_ext();
    results();
  end
endmodule : tcs_clock_source_tb

`default_nettype wire
